// [closed_loop_tuning_defs.vh]
// Purpose: shared constants for the closed-loop tuning register bank
// Assumes: APB byte addresses are four times the register index
// Notes: definitions only
`ifndef CLOSED_LOOP_TUNING_DEFS_VH
`define CLOSED_LOOP_TUNING_DEFS_VH

// Register indices and byte addresses
`define IDX_SETTINGS_TWO 8'h8A
`define IDX_SETTINGS_THREE 8'h8C
`define IDX_SETTINGS_FOUR 8'h8E
`define IDX_DECODE_STATUS 8'h90
`define ADDR_SETTINGS_TWO {2'h0, `IDX_SETTINGS_TWO, 2'h0}
`define ADDR_SETTINGS_THREE {2'h0, `IDX_SETTINGS_THREE, 2'h0}
`define ADDR_SETTINGS_FOUR {2'h0, `IDX_SETTINGS_FOUR, 2'h0}
`define ADDR_DECODE_STATUS {2'h0, `IDX_DECODE_STATUS, 2'h0}

// Reset values
`define RST_SETTINGS_TWO 32'h00000000
`define RST_SETTINGS_THREE 32'h00000000
`define RST_SETTINGS_FOUR 32'h00000000

// Settings two fields
`define HALT_MSB 30
`define HALT_LSB 28
`define BRK_TIME_MSB 27
`define BRK_TIME_LSB 24
`define SPIN_THR_MSB 23
`define SPIN_THR_LSB 20
`define BRK_THR_MSB 19
`define BRK_THR_LSB 16
`define RES_MSB 15
`define RES_LSB 8
`define IND_MSB 7
`define IND_LSB 0

// Settings three fields
`define BEMF_MSB 30
`define BEMF_LSB 23
`define CUR_KP_MSB 22
`define CUR_KP_LSB 13
`define CUR_KI_MSB 12
`define CUR_KI_LSB 3
`define VEL_KP_HI_MSB 2
`define VEL_KP_HI_LSB 0

// Settings four fields
`define VEL_KP_LO_MSB 30
`define VEL_KP_LO_LSB 24
`define MAX_SPEED_MSB 13
`define MAX_SPEED_LSB 0

// Halt method codes
`define HALT_HIZ 3'h0
`define HALT_LOW_BRAKE 3'h2
`define HALT_HIGH_BRAKE 3'h3
`define HALT_SPIN_DOWN 3'h4
`define HALT_ALIGN_BRAKE 3'h5

// Gain scale factors
`define CUR_KI_MULT 10'h3E8
`define VEL_KP_DIV_MULT 7'h64

// Timing
`define CLK_PERIOD_NS 10
`define BRAKE_TICK_NS 1000000
`define BRAKE_TICK_CYCLES (`BRAKE_TICK_NS / `CLK_PERIOD_NS)

`endif

// [speed_threshold_scale.v]
// Purpose: percentage-of-maximum speed threshold from a 4-bit code
// Assumes: max_speed in the same units as the speed estimate
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module speed_threshold_scale (
    // Setting
    input wire [3:0] code,
    input wire [13:0] max_speed,
    // Result
    output wire [13:0] threshold
);
    reg [9:0] tenths;
    wire [23:0] product;
    wire [23:0] quotient;

    // Scale in tenths of a percent so 2.5 % stays exact
    always @* begin
        case (code)
            4'h0: tenths = 10'h3E8;
            4'h1: tenths = 10'h384;
            4'h2: tenths = 10'h320;
            4'h3: tenths = 10'h2BC;
            4'h4: tenths = 10'h258;
            4'h5: tenths = 10'h1F4;
            4'h6: tenths = 10'h1C2;
            4'h7: tenths = 10'h190;
            4'h8: tenths = 10'h15E;
            4'h9: tenths = 10'h12C;
            4'hA: tenths = 10'h0FA;
            4'hB: tenths = 10'h0C8;
            4'hC: tenths = 10'h096;
            4'hD: tenths = 10'h064;
            4'hE: tenths = 10'h032;
            default: tenths = 10'h019;
        endcase
    end

    assign product = {10'h000, max_speed} * {14'h0000, tenths};
    assign quotient = product / 24'h0003E8;
    assign threshold = quotient[13:0];
endmodule // speed_threshold_scale

// [gain_code_decode.v]
// Purpose: split a 10-bit gain code into mantissa and power-of-ten divisor
// Assumes: upper two bits are the exponent, lower eight the mantissa
// Notes: divisor is 1, 10, 100 or 1000
`timescale 1ns/1ps
module gain_code_decode (
    // Code
    input wire [9:0] code,
    // Decoded
    output wire [7:0] mantissa,
    output reg [9:0] divisor
);
    assign mantissa = code[7:0];

    always @* begin
        case (code[9:8])
            2'h0: divisor = 10'h001;
            2'h1: divisor = 10'h00A;
            2'h2: divisor = 10'h064;
            default: divisor = 10'h3E8;
        endcase
    end
endmodule // gain_code_decode

// [closed_loop_tuning_regs.v]
// Purpose: closed-loop tuning registers with decoded settings and halt sequencer
// Assumes: APB slave with zero wait states, one 100 MHz clock
// Notes: motor_speed_hz comes from logic on pclk; brake_pin is a raw pin
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "closed_loop_tuning_defs.vh"

// Contract
// - A 3-bit halt method field picks hi-Z, low-side, high-side, spin-down or align stopping.
// - A 4-bit brake duration field gives 1 ms for codes 0-4 then 5 ms up to 15000 ms.
// - A 4-bit spin-down limit gives a speed from 100 % down to 2.5 % of maximum speed.
// - A 4-bit braking limit on the same scale gates the brake pin and the braking halts.
// - An 8-bit phase resistance code is held for the control algorithm.
// - An 8-bit phase inductance code in the low byte is held for the control algorithm.
// - An 8-bit back-EMF constant code is held for the control algorithm.
// - The current proportional gain is the low 8-bit mantissa over ten to the 2-bit exponent.
// - The current integral gain is 1000 times the mantissa over ten to the exponent.
// - Zero in the current gain fields selects automatically computed current gains.
// - The low three bits hold the top of the velocity gain, scaled by 0.01.
// - The velocity gain joins those three bits with seven more from the next word.
// - Percentage limits are scaled against a 14-bit maximum speed in another word.
module closed_loop_tuning_regs #(
    parameter integer TICK_CYCLES = `BRAKE_TICK_CYCLES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Halt control
    input wire halt_req,
    input wire brake_pin,
    input wire [13:0] motor_speed_hz,
    // Bridge state
    output reg bridge_hiz_ff,
    output reg low_side_brake_ff,
    output reg high_side_brake_ff,
    output reg align_brake_ff,
    output reg spin_down_active_ff,
    output reg halt_done_ff,
    // Decoded settings
    output reg [13:0] brake_time_ms_ff,
    output reg [13:0] spin_down_thr_hz_ff,
    output reg [13:0] brake_thr_hz_ff,
    output reg [7:0] phase_resistance_code_ff,
    output reg [7:0] phase_inductance_code_ff,
    output reg [7:0] back_emf_constant_code_ff,
    output reg current_gain_auto_ff,
    output reg [7:0] current_prop_mant_ff,
    output reg [9:0] current_prop_div_ff,
    output reg [17:0] current_integ_num_ff,
    output reg [9:0] current_integ_div_ff,
    output reg [7:0] velocity_prop_mant_ff,
    output reg [16:0] velocity_prop_div_ff
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_COAST = 3'h1;
    localparam [2:0] ST_SPIN = 3'h2;
    localparam [2:0] ST_BRAKE = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;
    localparam [2:0] ST_PIN_BRAKE = 3'h5;
    localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
    localparam [16:0] TICK_LAST = TICK_LAST_W[16:0];

    reg [31:0] settings_two_ff;
    reg [31:0] settings_three_ff;
    reg [31:0] settings_four_ff;
    reg [31:0] rdata_ff;
    reg err_ff;
    reg pin_meta_ff;
    reg pin_sync_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [2:0] method_ff;
    reg [2:0] nxt_method;
    reg [16:0] tick_cnt_ff;
    reg [13:0] ms_left_ff;
    reg [13:0] nxt_brake_ms;
    reg [31:0] nxt_rdata;
    reg nxt_err;
    wire setup_phase;
    wire write_strobe;
    wire tick;
    wire [2:0] halt_field;
    wire [9:0] cur_kp_code;
    wire [9:0] cur_ki_code;
    wire [9:0] vel_kp_code;
    wire [13:0] max_speed;
    wire [13:0] spin_thr;
    wire [13:0] brake_thr;
    wire [7:0] cur_kp_mant;
    wire [9:0] cur_kp_div;
    wire [7:0] cur_ki_mant;
    wire [9:0] cur_ki_div;
    wire [7:0] vel_kp_mant;
    wire [9:0] vel_kp_div;
    wire [31:0] status_word;
    wire below_brake;
    wire below_spin;

    // APB handshake: read data is prepared in the setup cycle, so no wait states
    assign setup_phase = psel & ~penable;
    assign write_strobe = psel & penable & pwrite & ~err_ff;
    assign pready = 1'b1;
    assign prdata = rdata_ff;
    assign pslverr = psel & penable & err_ff;

    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err = 1'b0;
        case (paddr)
            `ADDR_SETTINGS_TWO: nxt_rdata = settings_two_ff;
            `ADDR_SETTINGS_THREE: nxt_rdata = settings_three_ff;
            `ADDR_SETTINGS_FOUR: nxt_rdata = settings_four_ff;
            `ADDR_DECODE_STATUS: nxt_rdata = status_word;
            default: nxt_err = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h00000000;
            err_ff <= 1'b0;
        end else if (setup_phase) begin
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    // All 32 bits are stored, the reserved top bit included
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings_two_ff <= `RST_SETTINGS_TWO;
            settings_three_ff <= `RST_SETTINGS_THREE;
            settings_four_ff <= `RST_SETTINGS_FOUR;
        end else if (write_strobe) begin
            if (paddr == `ADDR_SETTINGS_TWO) begin
                settings_two_ff <= pwdata;
            end
            if (paddr == `ADDR_SETTINGS_THREE) begin
                settings_three_ff <= pwdata;
            end
            if (paddr == `ADDR_SETTINGS_FOUR) begin
                settings_four_ff <= pwdata;
            end
        end
    end

    // Field extraction
    assign halt_field = settings_two_ff[`HALT_MSB:`HALT_LSB];
    assign max_speed = settings_four_ff[`MAX_SPEED_MSB:`MAX_SPEED_LSB];
    assign cur_kp_code = settings_three_ff[`CUR_KP_MSB:`CUR_KP_LSB];
    assign cur_ki_code = settings_three_ff[`CUR_KI_MSB:`CUR_KI_LSB];
    // Three upper bits here, seven lower bits in the following word
    assign vel_kp_code = {settings_three_ff[`VEL_KP_HI_MSB:`VEL_KP_HI_LSB],
                          settings_four_ff[`VEL_KP_LO_MSB:`VEL_KP_LO_LSB]};

    speed_threshold_scale u_spin_thr (
        .code(settings_two_ff[`SPIN_THR_MSB:`SPIN_THR_LSB]),
        .max_speed(max_speed),
        .threshold(spin_thr)
    );

    speed_threshold_scale u_brake_thr (
        .code(settings_two_ff[`BRK_THR_MSB:`BRK_THR_LSB]),
        .max_speed(max_speed),
        .threshold(brake_thr)
    );

    gain_code_decode u_cur_kp (
        .code(cur_kp_code),
        .mantissa(cur_kp_mant),
        .divisor(cur_kp_div)
    );

    gain_code_decode u_cur_ki (
        .code(cur_ki_code),
        .mantissa(cur_ki_mant),
        .divisor(cur_ki_div)
    );

    gain_code_decode u_vel_kp (
        .code(vel_kp_code),
        .mantissa(vel_kp_mant),
        .divisor(vel_kp_div)
    );

    // Brake duration table in milliseconds
    always @* begin
        case (settings_two_ff[`BRK_TIME_MSB:`BRK_TIME_LSB])
            4'h5: nxt_brake_ms = 14'h0005;
            4'h6: nxt_brake_ms = 14'h000A;
            4'h7: nxt_brake_ms = 14'h0032;
            4'h8: nxt_brake_ms = 14'h0064;
            4'h9: nxt_brake_ms = 14'h00FA;
            4'hA: nxt_brake_ms = 14'h01F4;
            4'hB: nxt_brake_ms = 14'h03E8;
            4'hC: nxt_brake_ms = 14'h09C4;
            4'hD: nxt_brake_ms = 14'h1388;
            4'hE: nxt_brake_ms = 14'h2710;
            4'hF: nxt_brake_ms = 14'h3A98;
            default: nxt_brake_ms = 14'h0001;
        endcase
    end

    // Decoded settings are registered so they settle one cycle after a write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_time_ms_ff <= 14'h0001;
            spin_down_thr_hz_ff <= 14'h0000;
            brake_thr_hz_ff <= 14'h0000;
            phase_resistance_code_ff <= 8'h00;
            phase_inductance_code_ff <= 8'h00;
            back_emf_constant_code_ff <= 8'h00;
            current_gain_auto_ff <= 1'b1;
            current_prop_mant_ff <= 8'h00;
            current_prop_div_ff <= 10'h001;
            current_integ_num_ff <= 18'h00000;
            current_integ_div_ff <= 10'h001;
            velocity_prop_mant_ff <= 8'h00;
            velocity_prop_div_ff <= 17'h00064;
        end else begin
            brake_time_ms_ff <= nxt_brake_ms;
            spin_down_thr_hz_ff <= spin_thr;
            brake_thr_hz_ff <= brake_thr;
            phase_resistance_code_ff <= settings_two_ff[`RES_MSB:`RES_LSB];
            phase_inductance_code_ff <= settings_two_ff[`IND_MSB:`IND_LSB];
            back_emf_constant_code_ff <= settings_three_ff[`BEMF_MSB:`BEMF_LSB];
            current_gain_auto_ff <= (cur_kp_code == 10'h000) &&
                                    (cur_ki_code == 10'h000);
            current_prop_mant_ff <= cur_kp_mant;
            current_prop_div_ff <= cur_kp_div;
            current_integ_num_ff <= {10'h000, cur_ki_mant} * {8'h00, `CUR_KI_MULT};
            current_integ_div_ff <= cur_ki_div;
            velocity_prop_mant_ff <= vel_kp_mant;
            velocity_prop_div_ff <= {7'h00, vel_kp_div} * {10'h000, `VEL_KP_DIV_MULT};
        end
    end

    // Brake pin synchroniser
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= brake_pin;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign below_brake = (motor_speed_hz <= brake_thr_hz_ff);
    assign below_spin = (motor_speed_hz <= spin_down_thr_hz_ff);

    // Millisecond tick runs only while braking so the first tick is a full one
    assign tick = (state_ff == ST_BRAKE) && (tick_cnt_ff == TICK_LAST);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 17'h00000;
        end else if (state_ff != ST_BRAKE || tick) begin
            tick_cnt_ff <= 17'h00000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 17'h00001;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_left_ff <= 14'h0000;
        end else if (state_ff == ST_COAST) begin
            ms_left_ff <= brake_time_ms_ff;
        end else if (tick && ms_left_ff != 14'h0000) begin
            ms_left_ff <= ms_left_ff - 14'h0001;
        end
    end

    // Halt sequencer
    always @* begin
        nxt_state = state_ff;
        nxt_method = method_ff;
        case (state_ff)
            ST_IDLE: begin
                if (halt_req) begin
                    nxt_method = halt_field;
                    case (halt_field)
                        `HALT_SPIN_DOWN: nxt_state = ST_SPIN;
                        `HALT_LOW_BRAKE,
                        `HALT_HIGH_BRAKE,
                        `HALT_ALIGN_BRAKE: nxt_state = ST_COAST;
                        // Reserved and undefined codes fall back to hi-Z
                        default: nxt_state = ST_DONE;
                    endcase
                end else if (pin_sync_ff && below_brake) begin
                    nxt_state = ST_PIN_BRAKE;
                end
            end
            ST_PIN_BRAKE: begin
                if (halt_req || !pin_sync_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SPIN: begin
                if (!halt_req) begin
                    nxt_state = ST_IDLE;
                end else if (below_spin) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_COAST: begin
                if (!halt_req) begin
                    nxt_state = ST_IDLE;
                end else if (below_brake) begin
                    nxt_state = ST_BRAKE;
                end
            end
            ST_BRAKE: begin
                if (!halt_req) begin
                    nxt_state = ST_IDLE;
                end else if (tick && ms_left_ff == 14'h0001) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!halt_req) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // The method is latched at halt start so a write mid-stop cannot swap brakes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            method_ff <= `HALT_HIZ;
        end else begin
            state_ff <= nxt_state;
            method_ff <= nxt_method;
        end
    end

    // Bridge controls follow the next state so they line up with state_ff
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_hiz_ff <= 1'b0;
            low_side_brake_ff <= 1'b0;
            high_side_brake_ff <= 1'b0;
            align_brake_ff <= 1'b0;
            spin_down_active_ff <= 1'b0;
            halt_done_ff <= 1'b0;
        end else begin
            bridge_hiz_ff <= (nxt_state == ST_COAST) || (nxt_state == ST_DONE);
            low_side_brake_ff <= (nxt_state == ST_PIN_BRAKE) ||
                                 ((nxt_state == ST_BRAKE) &&
                                  (nxt_method == `HALT_LOW_BRAKE));
            high_side_brake_ff <= (nxt_state == ST_BRAKE) &&
                                  (nxt_method == `HALT_HIGH_BRAKE);
            align_brake_ff <= (nxt_state == ST_BRAKE) &&
                              (nxt_method == `HALT_ALIGN_BRAKE);
            spin_down_active_ff <= (nxt_state == ST_SPIN);
            halt_done_ff <= (nxt_state == ST_DONE);
        end
    end

    // Status: state, pin, auto-gain flag, remaining brake time
    assign status_word = {2'h0, ms_left_ff, 8'h00, method_ff,
                          current_gain_auto_ff, pin_sync_ff, state_ff};

endmodule // closed_loop_tuning_regs

// [closed_loop_tuning_regs_properties.sv]
// Purpose: port-level properties of the closed-loop tuning register bank
// Assumes: zero-wait APB slave on pclk, asynchronous active-low reset
// Notes: decoded outputs lag the write edge by two edges
`timescale 1ns/1ps
`include "closed_loop_tuning_defs.vh"
module closed_loop_tuning_props #(
    parameter integer TICK_CYCLES = 10
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Halt
    input wire halt_req,
    input wire bridge_hiz_ff,
    input wire low_side_brake_ff,
    input wire high_side_brake_ff,
    input wire align_brake_ff,
    input wire spin_down_active_ff,
    input wire halt_done_ff,
    // Decoded
    input wire [13:0] brake_time_ms_ff,
    input wire [7:0] phase_inductance_code_ff,
    input wire [7:0] back_emf_constant_code_ff,
    input wire current_gain_auto_ff,
    input wire [7:0] current_prop_mant_ff,
    input wire [17:0] current_integ_num_ff,
    input wire [7:0] velocity_prop_mant_ff
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam int BRK[16] = '{1, 1, 1, 1, 1, 5, 10, 50, 100, 250, 500, 1000, 2500, 5000,
        10000, 15000};
    wire acc = psel && penable;
    wire mapped = paddr == `ADDR_SETTINGS_TWO || paddr == `ADDR_SETTINGS_THREE ||
        paddr == `ADDR_SETTINGS_FOUR || paddr == `ADDR_DECODE_STATUS;
    wire wr2 = acc && pwrite && paddr == `ADDR_SETTINGS_TWO;
    wire wr3 = acc && pwrite && paddr == `ADDR_SETTINGS_THREE;
    wire wr4 = acc && pwrite && paddr == `ADDR_SETTINGS_FOUR;
    property p_err_map; acc && !mapped |-> pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("no error on unmapped access");
    property p_err_idle; !acc |-> !pslverr; endproperty
    a_err_idle: assert property (p_err_idle) else $error("error outside access");
    property p_rd_zero; acc && !pwrite && !mapped |-> prdata == 32'h0; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
    property p_brk; wr2 |-> ##2 brake_time_ms_ff == BRK[$past(pwdata[27:24], 2)]; endproperty
    a_brk: assert property (p_brk) else $error("brake time decode wrong");
    property p_ind; wr2 |-> ##2 phase_inductance_code_ff == $past(pwdata[7:0], 2); endproperty
    a_ind: assert property (p_ind) else $error("inductance code wrong");
    property p_bemf; wr3 |-> ##2 back_emf_constant_code_ff == $past(pwdata[30:23], 2);
    endproperty
    a_bemf: assert property (p_bemf) else $error("back-emf code wrong");
    property p_auto; wr3 |-> ##2 current_gain_auto_ff == ($past(pwdata[22:3], 2) == 20'h0);
    endproperty
    a_auto: assert property (p_auto) else $error("auto gain flag wrong");
    property p_ki; wr3 |-> ##2 current_prop_mant_ff == $past(pwdata[20:13], 2) &&
        current_integ_num_ff == 18'd1000 * $past(pwdata[10:3], 2); endproperty
    a_ki: assert property (p_ki) else $error("current gain decode wrong");
    property p_vel; wr4 |-> ##2 velocity_prop_mant_ff[6:0] == $past(pwdata[30:24], 2);
    endproperty
    a_vel: assert property (p_vel) else $error("velocity gain low bits wrong");
    property p_drop; $fell(halt_req) |=> !(high_side_brake_ff || align_brake_ff ||
        spin_down_active_ff || halt_done_ff); endproperty
    a_drop: assert property (p_drop) else $error("halt outputs stay after release");
    property p_done; halt_done_ff |-> bridge_hiz_ff && !low_side_brake_ff; endproperty
    a_done: assert property (p_done) else $error("done without hi-Z");
    c_wr2: cover property (wr2);
    c_done: cover property (halt_done_ff);
    c_err: cover property (acc && pslverr);
endmodule // closed_loop_tuning_props

bind closed_loop_tuning_regs closed_loop_tuning_props #(.TICK_CYCLES(TICK_CYCLES))
    i_closed_loop_tuning_props (.*);

// [tb_top.sv]
// Purpose: self-checking bench for the closed-loop tuning register bank
// Assumes: APB master tasks, brake tick shortened to 10 cycles
// Notes: max speed 9999 so percentage limits exercise truncation
`timescale 1ns/1ps
`include "closed_loop_tuning_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
`define WAITFOR(c) begin n = 0; while ((c) !== 1'b1 && n < 40) begin \
    @(posedge pclk); n++; end if ((c) !== 1'b1) tmo(); end
module tb_top;
    localparam int TK = 10;
    localparam int BRK[16] = '{1, 1, 1, 1, 1, 5, 10, 50, 100, 250, 500, 1000, 2500, 5000,
        10000, 15000};
    localparam int PCT[16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200,
        150, 100, 50, 25};
    localparam int P10[4] = '{1, 10, 100, 1000};
    localparam [11:0] A[3] = '{`ADDR_SETTINGS_TWO, `ADDR_SETTINGS_THREE, `ADDR_SETTINGS_FOUR};
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, halt_req = 0, brake_pin = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg [13:0] motor_speed_hz = 0;
    wire [31:0] prdata;
    wire pready, pslverr, bridge_hiz_ff, low_side_brake_ff, high_side_brake_ff, align_brake_ff;
    wire spin_down_active_ff, halt_done_ff, current_gain_auto_ff;
    wire [13:0] brake_time_ms_ff, spin_down_thr_hz_ff, brake_thr_hz_ff;
    wire [7:0] phase_resistance_code_ff, phase_inductance_code_ff, back_emf_constant_code_ff;
    wire [7:0] current_prop_mant_ff, velocity_prop_mant_ff;
    wire [9:0] current_prop_div_ff, current_integ_div_ff;
    wire [17:0] current_integ_num_ff;
    wire [16:0] velocity_prop_div_ff;
    integer bad_count = 0, checks_done = 0, n, i;
    reg [31:0] rd;
    reg err;
    closed_loop_tuning_regs #(.TICK_CYCLES(TK)) i_closed_loop_tuning_regs (.*);
    initial forever #5 pclk = ~pclk;
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic tmo;
        bad_count++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict();
    endtask
    task automatic apb(input bit w, input [11:0] a, input [31:0] d);
        integer k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) tmo();
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function logic drv(input [2:0] m);
        drv = m == 3'h2 ? low_side_brake_ff : m == 3'h3 ? high_side_brake_ff : align_brake_ff;
    endfunction
    task automatic halt_run(input [2:0] m, input [3:0] t, input bit slow);
        integer c;
        // Both limits at 50 % so a full-scale speed must coast or spin first
        apb(1, `ADDR_SETTINGS_TWO, {1'b0, m, t, 4'h5, 4'h5, 16'h0});
        motor_speed_hz <= slow ? 14'h3FFF : 14'h0;
        halt_req <= 1;
        repeat (4) @(posedge pclk);
        if (slow) begin
            `CHK(m == 3'h4 ? spin_down_active_ff : bridge_hiz_ff, 1'b1)
            motor_speed_hz <= 14'h0;
        end
        if (m == 3'h2 || m == 3'h3 || m == 3'h5) begin
            `WAITFOR(drv(m))
            c = 0;
            while (drv(m) === 1'b1 && c < TK * BRK[t] + TK) begin
                @(posedge pclk);
                c++;
            end
            // Tick restarts on entering the brake, yet the window still allows up to one tick short
            `CHK(c >= TK * BRK[t] - TK && c <= TK * BRK[t] + 1, 1'b1)
        end
        `WAITFOR(halt_done_ff)
        `CHK({bridge_hiz_ff, low_side_brake_ff, high_side_brake_ff, align_brake_ff}, 4'h8)
        apb(0, `ADDR_DECODE_STATUS, 0);
        `CHK(rd[7:0], {m, 2'h0, 3'h4})
        halt_req <= 0;
        repeat (2) @(posedge pclk);
        `CHK({bridge_hiz_ff, spin_down_active_ff, halt_done_ff}, 3'h0)
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        `CHK({brake_time_ms_ff, current_gain_auto_ff, velocity_prop_div_ff}, {14'd1, 1'b1, 17'd100})
        for (i = 0; i < 3; i++) begin
            apb(0, A[i], 0);
            `CHK(rd, 32'h0)
            apb(1, A[i], 32'hF5A5C33C);
            apb(0, A[i], 0);
            `CHK({rd, err}, {32'hF5A5C33C, 1'b0})
        end
        apb(1, 12'h300, 32'h12345678);
        `CHK(err, 1'b1)
        apb(0, 12'h300, 0);
        `CHK({rd, err}, {32'h0, 1'b1})
        apb(1, `ADDR_SETTINGS_FOUR, {1'b0, 7'h2A, 10'h0, 14'h270F});
        for (i = 0; i < 16; i++) begin
            apb(1, `ADDR_SETTINGS_TWO, {4'h0, i[3:0], i[3:0], 4'hF - i[3:0], 8'h5A ^ i[7:0],
                8'hC3 + i[7:0]});
            repeat (2) @(posedge pclk);
            `CHK(brake_time_ms_ff, BRK[i])
            `CHK(spin_down_thr_hz_ff, 9999 * PCT[i] / 1000)
            `CHK(brake_thr_hz_ff, 9999 * PCT[15 - i] / 1000)
            `CHK(phase_resistance_code_ff, 8'h5A ^ i[7:0])
            `CHK(phase_inductance_code_ff, 8'hC3 + i[7:0])
        end
        for (i = 0; i < 4; i++) begin
            apb(1, `ADDR_SETTINGS_THREE, {1'b1, 8'h3C + i[7:0], i[1:0], 8'hE1 - i[7:0],
                2'h3 - i[1:0], 8'h2B + i[7:0], 3'h5});
            repeat (2) @(posedge pclk);
            `CHK(back_emf_constant_code_ff, 8'h3C + i[7:0])
            `CHK({current_prop_mant_ff, current_prop_div_ff}, {8'hE1 - i[7:0], P10[i][9:0]})
            `CHK(current_integ_num_ff, 1000 * (8'h2B + i))
            `CHK(current_integ_div_ff, P10[3 - i])
            `CHK(current_gain_auto_ff, 1'b0)
            `CHK({velocity_prop_mant_ff, velocity_prop_div_ff}, {8'hAA, 17'd10000})
        end
        apb(1, `ADDR_SETTINGS_THREE, 32'h00000005);
        repeat (2) @(posedge pclk);
        `CHK(current_gain_auto_ff, 1'b1)
        apb(1, `ADDR_SETTINGS_THREE, 32'h00000008);
        repeat (2) @(posedge pclk);
        `CHK(current_gain_auto_ff, 1'b0)
        for (i = 0; i < 8; i++) halt_run(i[2:0], i == 2 ? 4'h5 : 4'h0, i >= 2 && i <= 5);
        brake_pin <= 1;
        `WAITFOR(low_side_brake_ff)
        brake_pin <= 0;
        `WAITFOR(!low_side_brake_ff)
        motor_speed_hz <= 14'h3FFF;
        brake_pin <= 1;
        repeat (8) @(posedge pclk);
        `CHK(low_side_brake_ff, 1'b0)
        print_verdict();
    end
endmodule // tb_top
